// ==== hw/msi_timer_pkg.sv ====
// Package: offsets, field positions, reset values for the config group
package msi_timer_pkg;
    localparam logic [7:0]  OFS_MSG_CTRL    = 8'h4C;
    localparam logic [7:0]  OFS_ADDR_LO     = 8'h50;
    localparam logic [7:0]  OFS_ADDR_HI     = 8'h54;
    localparam logic [7:0]  OFS_PAYLOAD     = 8'h58;
    localparam logic [7:0]  OFS_VENDOR_CAP  = 8'h64;
    localparam logic [7:0]  OFS_SCRATCH0    = 8'h68;
    localparam logic [7:0]  OFS_SCRATCH1    = 8'h6C;
    localparam logic [7:0]  OFS_TIMER_OVR   = 8'h70;
    localparam logic [7:0]  MSI_CAP_ID      = 8'h05;
    localparam logic [7:0]  MSI_NEXT_PTR    = 8'h64;
    localparam logic [7:0]  VND_CAP_ID      = 8'h09;
    localparam logic [7:0]  VND_NEXT_PTR    = 8'hB0;
    localparam logic [15:0] VND_LENGTH      = 16'h0034;
    localparam logic [2:0]  MM_CAPABLE      = 3'h2;
    localparam int          BIT_MSI_EN      = 16;
    localparam int          BIT_ADDR64      = 23;
    localparam int          BIT_REPLAY_EN   = 12;
    localparam int          BIT_PM_DIS      = 13;
    localparam int          BIT_MSI_DIS     = 14;
    localparam int          BIT_ACK_EN      = 30;
    localparam logic [31:0] RST_SCRATCH0    = 32'h0400_1060;
    localparam logic [31:0] RST_SCRATCH1    = 32'h0000_0800;
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
    localparam logic [31:0] RST_TIMER_OVR   = 32'h0000_0000;
    localparam logic [31:0] MASK_ADDR_LO    = 32'hFFFF_FFFC;
    localparam logic [31:0] MASK_PAYLOAD    = 32'h0000_FFFF;
    localparam logic [31:0] MASK_TIMER_OVR  = 32'h7FFF_7FFF;
    localparam logic [31:0] MASK_TIMER_RW   = MASK_TIMER_OVR & ~32'h0000_6000;
endpackage : msi_timer_pkg

// ==== hw/cfg_word_reg.sv ====
// Byte-enabled configuration word with preload port
module cfg_word_reg
    import msi_timer_pkg::*;
#(
    parameter logic [31:0] RESET_VAL = 32'h0000_0000,
    parameter logic [31:0] WR_MASK   = 32'hFFFF_FFFF
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Host write
    input  wire logic        wrEn,
    input  wire logic [3:0]  byteEn,
    input  wire logic [31:0] wrData,
    // Preload of defaults
    input  wire logic        loadEn,
    input  wire logic [31:0] loadData,
    // Value
    output logic      [31:0] value
);
    logic [31:0] value_ff;
    logic [31:0] nxt_value;
    logic [31:0] laneMask;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign laneMask[8*g +: 8] = {8{byteEn[g]}};
        end
    endgenerate

    assign nxt_value = loadEn ? loadData :
                       wrEn ? ((value_ff & ~(laneMask & WR_MASK)) |
                               (wrData & laneMask & WR_MASK)) : value_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            value_ff <= RESET_VAL;
        end else begin
            value_ff <= nxt_value;
        end
    end

    assign value = value_ff;
endmodule : cfg_word_reg

// ==== hw/msi_and_link_timer_config_regs.sv ====
// Interrupt-message capability, vendor header, scratch and timer overrides
//
// Overview of operation
// - Enable clear: no interrupt message requested
// - Enable set with the message-disable override bit clear: messages allowed, legacy pin silenced
// - 64-bit address capable bit reads one
// - Address low dword aligned, low bits zero
// - Upper address used only with 64-bit
// - Vendor header identifier reads 09h
// - Vendor next pointer reads B0h
// - Vendor length field reads 0034h
// - Scratch zero read-write, resets 0400_1060h
// - Scratch one read-write, resets 0000_0800h
// - User replay time-out, 12 bits writable
// - Replay override enable selects user value
// - User ack latency, 14 bits writable
// - Ack override enable selects user value
// - Timer override word reloadable from SMBus or EEPROM
// - Interrupt-message capability identifier reads 05h
module msi_and_link_timer_config_regs
    import msi_timer_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Configuration request port
    input  wire logic        cfgRead,
    input  wire logic        cfgWrite,
    input  wire logic [7:0]  cfgAddr,
    input  wire logic [3:0]  cfgByteEn,
    input  wire logic [31:0] cfgWrData,
    output logic      [31:0] cfgRdData,
    output logic             cfgRdValid,
    output logic             cfgHit,
    // Default preload from SMBus or EEPROM
    input  wire logic        preloadEn,
    input  wire logic [31:0] preloadTimerOvr,
    // Interrupt request from the port
    input  wire logic        intRequest,
    input  wire logic [4:0]  intVector,
    // Interrupt message towards the link
    output logic             msgWrValid,
    output logic      [63:0] msgWrAddr,
    output logic      [31:0] msgWrData,
    output logic             msgWrAddr64,
    output logic             legacyIntAssert,
    // Link-layer timer overrides
    output logic      [11:0] replayUserValue,
    output logic             replayUserSel,
    output logic      [13:0] ackUserValue,
    output logic             ackUserSel,
    // Capability list steering
    output logic             pmCapPresent,
    output logic             msiCapPresent
);
    // ==================================================================
    // Decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a[7:2] == o[7:2]);
    endfunction : hit

    logic wrCtrl, wrLo, wrHi, wrPay, wrS0, wrS1, wrTmr;
    assign wrCtrl = cfgWrite && hit(cfgAddr, OFS_MSG_CTRL);
    assign wrLo   = cfgWrite && hit(cfgAddr, OFS_ADDR_LO);
    assign wrHi   = cfgWrite && hit(cfgAddr, OFS_ADDR_HI);
    assign wrPay  = cfgWrite && hit(cfgAddr, OFS_PAYLOAD);
    assign wrS0   = cfgWrite && hit(cfgAddr, OFS_SCRATCH0);
    assign wrS1   = cfgWrite && hit(cfgAddr, OFS_SCRATCH1);
    assign wrTmr  = cfgWrite && hit(cfgAddr, OFS_TIMER_OVR);

    // ==================================================================
    // Storage
    logic [31:0] addrLo, addrHi, payload, scratch0, scratch1, timerOvr;

    cfg_word_reg #(.RESET_VAL(RST_ZERO), .WR_MASK(MASK_ADDR_LO)) u_lo (
        .clk(clk), .resetn(resetn), .wrEn(wrLo), .byteEn(cfgByteEn),
        .wrData(cfgWrData), .loadEn(1'b0), .loadData(RST_ZERO),
        .value(addrLo));
    cfg_word_reg #(.RESET_VAL(RST_ZERO)) u_hi (
        .clk(clk), .resetn(resetn), .wrEn(wrHi), .byteEn(cfgByteEn),
        .wrData(cfgWrData), .loadEn(1'b0), .loadData(RST_ZERO),
        .value(addrHi));
    cfg_word_reg #(.RESET_VAL(RST_ZERO), .WR_MASK(MASK_PAYLOAD)) u_pay (
        .clk(clk), .resetn(resetn), .wrEn(wrPay), .byteEn(cfgByteEn),
        .wrData(cfgWrData), .loadEn(1'b0), .loadData(RST_ZERO),
        .value(payload));
    cfg_word_reg #(.RESET_VAL(RST_SCRATCH0)) u_s0 (
        .clk(clk), .resetn(resetn), .wrEn(wrS0), .byteEn(cfgByteEn),
        .wrData(cfgWrData), .loadEn(1'b0), .loadData(RST_ZERO),
        .value(scratch0));
    cfg_word_reg #(.RESET_VAL(RST_SCRATCH1)) u_s1 (
        .clk(clk), .resetn(resetn), .wrEn(wrS1), .byteEn(cfgByteEn),
        .wrData(cfgWrData), .loadEn(1'b0), .loadData(RST_ZERO),
        .value(scratch1));
    cfg_word_reg #(.RESET_VAL(RST_TIMER_OVR), .WR_MASK(MASK_TIMER_RW)) u_tmr (
        .clk(clk), .resetn(resetn), .wrEn(wrTmr), .byteEn(cfgByteEn),
        .wrData(cfgWrData), .loadEn(preloadEn),
        .loadData(preloadTimerOvr & MASK_TIMER_OVR),
        .value(timerOvr));

    // Message control: enable and granted message count
    logic       msiEn_ff;
    logic [2:0] mmEnable_ff;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            msiEn_ff    <= 1'b0;
            mmEnable_ff <= 3'h0;
        end else if (wrCtrl && cfgByteEn[2]) begin
            msiEn_ff    <= cfgWrData[BIT_MSI_EN];
            mmEnable_ff <= cfgWrData[22:20];
        end
    end

    // ==================================================================
    // Read mux
    logic [31:0] ctrlWord, vendorWord, rdMux;
    logic        rdHit;
    assign ctrlWord = {8'h00, 1'b1, mmEnable_ff, MM_CAPABLE, msiEn_ff,
                       MSI_NEXT_PTR, MSI_CAP_ID};
    assign vendorWord = {VND_LENGTH, VND_NEXT_PTR, VND_CAP_ID};

    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        case (cfgAddr[7:2])
            OFS_MSG_CTRL[7:2]:   rdMux = ctrlWord;
            OFS_ADDR_LO[7:2]:    rdMux = addrLo;
            OFS_ADDR_HI[7:2]:    rdMux = addrHi;
            OFS_PAYLOAD[7:2]:    rdMux = payload;
            OFS_VENDOR_CAP[7:2]: rdMux = vendorWord;
            OFS_SCRATCH0[7:2]:   rdMux = scratch0;
            OFS_SCRATCH1[7:2]:   rdMux = scratch1;
            OFS_TIMER_OVR[7:2]:  rdMux = timerOvr;
            default:             rdHit = 1'b0;
        endcase
    end

    // ==================================================================
    // Interrupt message generation
    logic [4:0] vecMask;
    logic       msiCapOn;
    logic       sendMsg;
    assign vecMask  = 5'((6'h01 << mmEnable_ff) - 6'h01);
    assign msiCapOn = !timerOvr[BIT_MSI_DIS];
    assign sendMsg  = intRequest && msiEn_ff && msiCapOn;

    logic        rdValid_ff, hit_ff, msgValid_ff, legacy_ff, msgAddr64_ff;
    logic [31:0] rdData_ff, msgData_ff;
    logic [63:0] msgAddr_ff;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdValid_ff  <= 1'b0;
            hit_ff      <= 1'b0;
            rdData_ff   <= 32'h0000_0000;
            msgValid_ff <= 1'b0;
            msgAddr_ff  <= 64'h0000_0000_0000_0000;
            msgData_ff  <= 32'h0000_0000;
            legacy_ff   <= 1'b0;
            msgAddr64_ff <= 1'b0;
        end else begin
            rdValid_ff  <= cfgRead;
            hit_ff      <= (cfgRead || cfgWrite) && rdHit;
            rdData_ff   <= cfgRead ? rdMux : 32'h0000_0000;
            msgValid_ff <= sendMsg;
            if (sendMsg) begin
                msgAddr_ff <= {(addrHi != 32'h0) ? addrHi : 32'h0,
                               addrLo[31:2], 2'b00};
                msgAddr64_ff <= (addrHi != 32'h0000_0000);
                msgData_ff <= {16'h0000, payload[15:5],
                               (payload[4:0] & ~vecMask) |
                               (intVector & vecMask)};
            end
            legacy_ff <= intRequest && !(msiEn_ff && msiCapOn);
        end
    end

    // ==================================================================
    // Outputs
    logic [31:0] tmr_ff;
    logic        pmPresent_ff, msiPresent_ff;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tmr_ff        <= RST_TIMER_OVR;
            pmPresent_ff  <= 1'b1;
            msiPresent_ff <= 1'b1;
        end else begin
            tmr_ff        <= timerOvr;
            pmPresent_ff  <= !timerOvr[BIT_PM_DIS];
            msiPresent_ff <= msiCapOn;
        end
    end

    assign cfgRdData       = rdData_ff;
    assign cfgRdValid      = rdValid_ff;
    assign cfgHit          = hit_ff;
    assign msgWrValid      = msgValid_ff;
    assign msgWrAddr       = msgAddr_ff;
    assign msgWrData       = msgData_ff;
    assign msgWrAddr64     = msgAddr64_ff;
    assign legacyIntAssert = legacy_ff;
    assign replayUserValue = tmr_ff[11:0];
    assign replayUserSel   = tmr_ff[BIT_REPLAY_EN];
    assign ackUserValue    = tmr_ff[29:16];
    assign ackUserSel      = tmr_ff[BIT_ACK_EN];
    assign pmCapPresent    = pmPresent_ff;
    assign msiCapPresent   = msiPresent_ff;

    // ==================================================================
    // Assertions
    a_no_msg_disabled: assert property (
        @(posedge clk) disable iff (!resetn)
        !msiEn_ff |=> !msgWrValid)
        else $error("message sent while disabled");
    a_legacy_silent: assert property (
        @(posedge clk) disable iff (!resetn)
        (msiEn_ff && msiCapOn) |=> !legacyIntAssert)
        else $error("legacy pin while messaging");
    a_msg_enabled: assert property (
        @(posedge clk) disable iff (!resetn)
        (intRequest && msiEn_ff && msiCapOn) |=> msgWrValid)
        else $error("message not sent while enabled");
    a_addr64_bit: assert property (
        @(posedge clk) disable iff (!resetn)
        (cfgRead && hit(cfgAddr, OFS_MSG_CTRL)) |=> cfgRdData[BIT_ADDR64])
        else $error("address width bit not read as one");
    a_addr_aligned: assert property (
        @(posedge clk) disable iff (!resetn)
        msgWrValid |-> (msgWrAddr[1:0] == 2'h0 &&
            msgWrAddr[31:2] == $past(addrLo[31:2])))
        else $error("message address low wrong");
    a_addr_low_read: assert property (
        @(posedge clk) disable iff (!resetn)
        (cfgRead && hit(cfgAddr, OFS_ADDR_LO)) |=> cfgRdData[1:0] == 2'h0)
        else $error("address low reserved bits not zero");
    a_addr_high_used: assert property (
        @(posedge clk) disable iff (!resetn)
        msgWrValid |-> (msgWrAddr[63:32] == $past(addrHi) &&
            msgWrAddr64 == ($past(addrHi) != 32'h0000_0000)))
        else $error("message address high wrong");
    a_vendor_header: assert property (
        @(posedge clk) disable iff (!resetn)
        (cfgRead && hit(cfgAddr, OFS_VENDOR_CAP)) |=>
            cfgRdData == 32'h0034_B009)
        else $error("vendor header wrong");
    a_vendor_next: assert property (
        @(posedge clk) disable iff (!resetn)
        (cfgRead && hit(cfgAddr, OFS_VENDOR_CAP)) |=>
            cfgRdData[15:8] == VND_NEXT_PTR)
        else $error("vendor next pointer wrong");
    a_vendor_length: assert property (
        @(posedge clk) disable iff (!resetn)
        (cfgRead && hit(cfgAddr, OFS_VENDOR_CAP)) |=>
            cfgRdData[31:16] == VND_LENGTH)
        else $error("vendor length wrong");
    a_scratch_write: assert property (
        @(posedge clk) disable iff (!resetn)
        (wrS0 && cfgByteEn == 4'hF) |=> scratch0 == $past(cfgWrData))
        else $error("scratch zero not written");
    a_scratch1_write: assert property (
        @(posedge clk) disable iff (!resetn)
        (wrS1 && cfgByteEn == 4'hF) |=> scratch1 == $past(cfgWrData))
        else $error("scratch one not written");
    a_replay_value: assert property (
        @(posedge clk) disable iff (!resetn)
        (wrTmr && cfgByteEn[1:0] == 2'h3 && !preloadEn) |=>
            ##1 replayUserValue == $past(cfgWrData[11:0], 2))
        else $error("replay user value not applied");
    a_timer_follow: assert property (
        @(posedge clk) disable iff (!resetn)
        ##1 replayUserSel == $past(timerOvr[BIT_REPLAY_EN]))
        else $error("replay select lag wrong");
    a_ack_value: assert property (
        @(posedge clk) disable iff (!resetn)
        (wrTmr && cfgByteEn[3:2] == 2'h3 && !preloadEn) |=>
            ##1 ackUserValue == $past(cfgWrData[29:16], 2))
        else $error("ack user value not applied");
    a_ack_select: assert property (
        @(posedge clk) disable iff (!resetn)
        (wrTmr && cfgByteEn[3] && !preloadEn) |=>
            ##1 ackUserSel == $past(cfgWrData[BIT_ACK_EN], 2))
        else $error("ack select not applied");
    a_preload_wins: assert property (
        @(posedge clk) disable iff (!resetn)
        preloadEn |=> ##1 ackUserValue == $past(preloadTimerOvr[29:16], 2))
        else $error("preload not applied");
    a_ro_flags_kept: assert property (
        @(posedge clk) disable iff (!resetn)
        (wrTmr && !preloadEn) |=> timerOvr[14:13] == $past(timerOvr[14:13]))
        else $error("disable flags changed by host write");
    a_msi_cap_id: assert property (
        @(posedge clk) disable iff (!resetn)
        (cfgRead && hit(cfgAddr, OFS_MSG_CTRL)) |=>
            cfgRdData[7:0] == MSI_CAP_ID)
        else $error("message capability identifier wrong");
    a_vector_mask: assert property (
        @(posedge clk) disable iff (!resetn)
        msgWrValid |-> ((msgWrData[4:0] ^ $past(payload[4:0]))
            >> $past(mmEnable_ff)) == 5'h00)
        else $error("vector bits beyond granted count");
    a_payload_upper: assert property (
        @(posedge clk) disable iff (!resetn)
        msgWrValid |-> (msgWrData[31:16] == 16'h0000 &&
            msgWrData[15:5] == $past(payload[15:5])))
        else $error("payload not sent as written");
    a_payload_read: assert property (
        @(posedge clk) disable iff (!resetn)
        (cfgRead && hit(cfgAddr, OFS_PAYLOAD)) |=>
            cfgRdData[31:16] == 16'h0000)
        else $error("payload upper half not zero");
    a_msg_cap_off: assert property (
        @(posedge clk) disable iff (!resetn)
        timerOvr[BIT_MSI_DIS] |=> !msgWrValid)
        else $error("message sent with capability removed");
    a_pm_presence: assert property (
        @(posedge clk) disable iff (!resetn)
        ##1 pmCapPresent == !$past(timerOvr[BIT_PM_DIS]))
        else $error("power capability presence lag wrong");
endmodule : msi_and_link_timer_config_regs

// ==== dv/cfg_host_model.sv ====
// Host model issuing configuration reads and writes
module cfg_host_model (
    // Clock
    input  wire logic        clk,
    // Request
    output logic             cfgRead,
    output logic             cfgWrite,
    output logic      [7:0]  cfgAddr,
    output logic      [3:0]  cfgByteEn,
    output logic      [31:0] cfgWrData,
    // Answer
    input  wire logic [31:0] cfgRdData,
    input  wire logic        cfgRdValid,
    input  wire logic        cfgHit
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // Idle levels
    initial begin
        cfgRead   = 1'b0;
        cfgWrite  = 1'b0;
        cfgAddr   = 8'hFF;
        cfgByteEn = 4'h0;
        cfgWrData = 32'hA5A5_A5A5;
    end
    // ====================
    // One-cycle write pulse, fields scrambled once released
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        @(posedge clk);
        cfgWrite  <= 1'b1;
        cfgAddr   <= a;
        cfgWrData <= d;
        cfgByteEn <= be;
        @(posedge clk);
        cfgWrite  <= 1'b0;
        cfgAddr   <= ~a;
        cfgWrData <= ~d;
        cfgByteEn <= ~be;
    endtask : wr
    // ====================
    // One-cycle read pulse, answer taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic v, output logic h);
        @(posedge clk);
        cfgRead <= 1'b1;
        cfgAddr <= a;
        @(posedge clk);
        cfgRead <= 1'b0;
        cfgAddr <= ~a;
        #1;
        d = cfgRdData;
        v = cfgRdValid;
        h = cfgHit;
    endtask : rd
endmodule : cfg_host_model

// ==== dv/tb_msi_and_link_timer_config_regs.sv ====
// Testbench for the interrupt-message and timer override registers
module tb_msi_and_link_timer_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import msi_timer_pkg::*;
    logic clk, resetn, cfgRead, cfgWrite, cfgRdValid, cfgHit, preloadEn;
    logic intRequest, msgWrValid, msgWrAddr64, legacyIntAssert;
    logic replayUserSel, ackUserSel, pmCapPresent, msiCapPresent;
    logic [7:0] cfgAddr;
    logic [3:0] cfgByteEn;
    logic [31:0] cfgWrData, cfgRdData, preloadTimerOvr, msgWrData;
    logic [4:0] intVector;
    logic [63:0] msgWrAddr;
    logic [11:0] replayUserValue;
    logic [13:0] ackUserValue;
    int fails, n_checks;
    cfg_host_model host (.clk(clk), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
        .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .cfgHit(cfgHit));
    msi_and_link_timer_config_regs dut (.clk(clk), .resetn(resetn),
        .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
        .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .cfgHit(cfgHit),
        .preloadEn(preloadEn), .preloadTimerOvr(preloadTimerOvr),
        .intRequest(intRequest), .intVector(intVector),
        .msgWrValid(msgWrValid), .msgWrAddr(msgWrAddr),
        .msgWrData(msgWrData), .msgWrAddr64(msgWrAddr64),
        .legacyIntAssert(legacyIntAssert),
        .replayUserValue(replayUserValue), .replayUserSel(replayUserSel),
        .ackUserValue(ackUserValue), .ackUserSel(ackUserSel),
        .pmCapPresent(pmCapPresent), .msiCapPresent(msiCapPresent));
    // ====================
    // Checking helpers
    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input logic h);
        logic [31:0] d;
        logic v, ht;
        host.rd(a, d, v, ht);
        chk("cfgRdValid", 64'h1, {63'h0, v});
        chk("cfgHit", {63'h0, h}, {63'h0, ht});
        chk($sformatf("read %h", a), {32'h0, e}, {32'h0, d});
    endtask : rchk
    task automatic tchk(input logic [11:0] rv, input logic rs,
                        input logic [13:0] av, input logic as_);
        repeat (3) @(posedge clk);
        #1;
        chk("timer outputs", {36'h0, rv, rs, av, as_},
            {36'h0, replayUserValue, replayUserSel, ackUserValue, ackUserSel});
    endtask : tchk
    task automatic irq(input logic [4:0] vec, input logic ev,
                       input logic [31:0] ed, input logic [63:0] ea,
                       input logic e64, input logic el);
        @(posedge clk);
        intRequest <= 1'b1;
        intVector  <= vec;
        @(posedge clk);
        intRequest <= 1'b0;
        intVector  <= ~vec;
        #1;
        chk("msgWrValid/legacy", {62'h0, ev, el},
            {62'h0, msgWrValid, legacyIntAssert});
        if (ev) begin
            chk("msgWrData", {32'h0, ed}, {32'h0, msgWrData});
            chk("msgWrAddr", ea, msgWrAddr);
            chk("msgWrAddr64", {63'h0, e64}, {63'h0, msgWrAddr64});
        end
    endtask : irq
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    // ====================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        test_done();
    end
    // ====================
    // Main sequence
    initial begin
        resetn = 1'b0;
        preloadEn = 1'b0;
        preloadTimerOvr = 32'h0;
        intRequest = 1'b0;
        intVector = 5'h0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        chk("cap present", 64'h3, {62'h0, pmCapPresent, msiCapPresent});
        rchk(OFS_MSG_CTRL, 32'h0084_6405, 1'b1);
        rchk(OFS_ADDR_LO, 32'h0, 1'b1);
        rchk(OFS_ADDR_HI, 32'h0, 1'b1);
        rchk(OFS_PAYLOAD, 32'h0, 1'b1);
        rchk(OFS_VENDOR_CAP, 32'h0034_B009, 1'b1);
        rchk(OFS_SCRATCH0, 32'h0400_1060, 1'b1);
        rchk(OFS_SCRATCH1, 32'h0000_0800, 1'b1);
        rchk(OFS_TIMER_OVR, 32'h0, 1'b1);
        rchk(8'h78, 32'h0, 1'b0);
        tchk(12'h0, 1'b0, 14'h0, 1'b0);
        $display("test reset_values done");
        host.wr(OFS_MSG_CTRL, 32'hFF21_FFFF, 4'hF);
        host.wr(OFS_ADDR_LO, 32'hFFFF_FFFF, 4'hF);
        host.wr(OFS_ADDR_HI, 32'hFFFF_FFFF, 4'hF);
        host.wr(OFS_PAYLOAD, 32'hFFFF_FFFF, 4'hF);
        host.wr(OFS_VENDOR_CAP, 32'hFFFF_FFFF, 4'hF);
        host.wr(OFS_SCRATCH0, 32'hFFFF_FFFF, 4'hF);
        host.wr(OFS_SCRATCH1, 32'hFFFF_FFFF, 4'hF);
        host.wr(OFS_TIMER_OVR, 32'hFFFF_FFFF, 4'hF);
        rchk(OFS_MSG_CTRL, 32'h00A5_6405, 1'b1);
        rchk(OFS_ADDR_LO, 32'hFFFF_FFFC, 1'b1);
        rchk(OFS_ADDR_HI, 32'hFFFF_FFFF, 1'b1);
        rchk(OFS_PAYLOAD, 32'h0000_FFFF, 1'b1);
        rchk(OFS_VENDOR_CAP, 32'h0034_B009, 1'b1);
        rchk(OFS_SCRATCH0, 32'hFFFF_FFFF, 1'b1);
        rchk(OFS_SCRATCH1, 32'hFFFF_FFFF, 1'b1);
        rchk(OFS_TIMER_OVR, 32'h7FFF_1FFF, 1'b1);
        tchk(12'hFFF, 1'b1, 14'h3FFF, 1'b1);
        host.wr(OFS_TIMER_OVR, 32'h2ABC_0123, 4'h3);
        rchk(OFS_TIMER_OVR, 32'h7FFF_0123, 1'b1);
        tchk(12'h123, 1'b0, 14'h3FFF, 1'b1);
        $display("test write_readback done");
        host.wr(OFS_ADDR_LO, 32'hFEE0_0000, 4'hF);
        host.wr(OFS_ADDR_HI, 32'h0000_0001, 4'hF);
        host.wr(OFS_PAYLOAD, 32'h0000_1230, 4'hF);
        irq(5'h05, 1'b1, 32'h1231, 64'h1_FEE0_0000, 1'b1, 1'b0);
        host.wr(OFS_ADDR_HI, 32'h0, 4'hF);
        irq(5'h06, 1'b1, 32'h1232, 64'hFEE0_0000, 1'b0, 1'b0);
        host.wr(OFS_MSG_CTRL, 32'h0, 4'hF);
        irq(5'h05, 1'b0, 32'h0, 64'h0, 1'b0, 1'b1);
        $display("test interrupt_message done");
        host.wr(OFS_MSG_CTRL, 32'h0021_0000, 4'h4);
        @(posedge clk);
        preloadEn <= 1'b1;
        preloadTimerOvr <= 32'h4123_6456;
        @(posedge clk);
        preloadEn <= 1'b0;
        preloadTimerOvr <= 32'hBEDC_9BA9;
        tchk(12'h456, 1'b0, 14'h0123, 1'b1);
        chk("cap present", 64'h0, {62'h0, pmCapPresent, msiCapPresent});
        rchk(OFS_TIMER_OVR, 32'h4123_6456, 1'b1);
        host.wr(OFS_TIMER_OVR, 32'h0, 4'hF);
        rchk(OFS_TIMER_OVR, 32'h0000_6000, 1'b1);
        irq(5'h01, 1'b0, 32'h0, 64'h0, 1'b0, 1'b1);
        $display("test preload done");
        test_done();
    end
endmodule : tb_msi_and_link_timer_config_regs
